//--- rtl/qsps_sequencer.sv
// burst-of-four sram read and write port sequencer with its array
module qsps_sequencer #(
  parameter int unsigned ADDR_W = qsps_pkg::ADDR_W_DEF,
  parameter int unsigned FIFO_DEPTH = qsps_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic k_rise_i,
  input wire logic kn_rise_i,
  input wire logic read_port_select_n_i,
  input wire logic write_port_select_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [qsps_pkg::DATA_W-1:0] d_i,
  input wire logic [qsps_pkg::LANE_N-1:0] byte_lane_write_select_n_i,
  output logic [qsps_pkg::DATA_W-1:0] q_o,
  output logic q_oe_o,
  output logic wr_ready_o
);
  import qsps_pkg::*;

  localparam int unsigned FW = ADDR_W + LANE_N + DATA_W;

  // refuse address widths the array cannot serve
  if (ADDR_W < 2 || ADDR_W > ADDR_W_DEF) begin : g_addr_chk
    $error("qsps_sequencer: ADDR_W must lie in 2..22");
  end

  logic [DATA_W-1:0] mem_q [2**ADDR_W];
  logic rise;
  logic rd_acc, wr_acc;
  logic rd_prev_q, rd_prev_d, wr_prev_q, wr_prev_d;
  logic [PIPE_N:1] rd_v_q, rd_v_d, wr_v_q, wr_v_d;
  logic [ADDR_W-1:0] rd_a_q [PIPE_N:1];
  logic [ADDR_W-1:0] rd_a_d [PIPE_N:1];
  logic [ADDR_W-1:0] wr_a_q [PIPE_N:1];
  logic [ADDR_W-1:0] wr_a_d [PIPE_N:1];
  logic rd_hit, wr_hit;
  logic [ADDR_W-1:0] rd_addr, wr_addr;
  logic [DATA_W-1:0] q_q, q_d;
  logic q_oe_q, q_oe_d, wr_ready_q;
  logic push, fifo_in_ready, dr_valid, dr_fire;
  logic [FW-1:0] push_data, dr_data;
  logic [ADDR_W-1:0] dr_addr;
  logic [LANE_N-1:0] dr_sel_n;
  logic [DATA_W-1:0] dr_word, dr_old, dr_merged;

  // any true or complement rise advances the sequencer
  assign rise = k_rise_i | kn_rise_i;

  always_comb begin
    rd_acc = k_rise_i & ~read_port_select_n_i & ~rd_prev_q;
    wr_acc = k_rise_i & ~write_port_select_n_i & ~wr_prev_q & ~rd_acc;
    rd_prev_d = k_rise_i ? rd_acc : rd_prev_q;
    wr_prev_d = k_rise_i ? wr_acc : wr_prev_q;
  end

  // hold without rises
  // request pipelines, one stage per rise, address carried along
  always_comb begin
    rd_v_d = rd_v_q;
    wr_v_d = wr_v_q;
    rd_a_d = rd_a_q;
    wr_a_d = wr_a_q;
    if (rise) begin
      rd_v_d = {rd_v_q[PIPE_N-1:1], rd_acc};
      wr_v_d = {wr_v_q[PIPE_N-1:1], wr_acc};
      rd_a_d[1] = addr_i;
      wr_a_d[1] = addr_i;
      for (int s = 2; s <= PIPE_N; s++) begin
        rd_a_d[s] = rd_a_q[s-1];
        wr_a_d[s] = wr_a_q[s-1];
      end
    end
  end

  always_comb begin
    rd_hit = 1'b0;
    rd_addr = '0;
    wr_hit = 1'b0;
    wr_addr = '0;
    for (int s = RD_FIRST; s <= RD_LAST; s++) begin
      if (rd_v_q[s]) begin
        rd_hit = 1'b1;
        rd_addr = rd_a_q[s] + ADDR_W'(s - RD_FIRST);
      end
    end
    for (int s = WR_FIRST; s <= WR_LAST; s++) begin
      if (wr_v_q[s]) begin
        wr_hit = 1'b1;
        wr_addr = wr_a_q[s] + ADDR_W'(s - WR_FIRST);
      end
    end
  end

  always_comb begin
    q_d = q_q;
    q_oe_d = q_oe_q;
    if (rise) begin
      q_oe_d = rd_hit;
      q_d = rd_hit ? mem_q[rd_addr] : q_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
      rd_v_q <= '0;
      wr_v_q <= '0;
      rd_a_q <= '{default: '0};
      wr_a_q <= '{default: '0};
      q_q <= Q_RESET;
      q_oe_q <= 1'b0;
      wr_ready_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_prev_d;
      wr_prev_q <= wr_prev_d;
      rd_v_q <= rd_v_d;
      wr_v_q <= wr_v_d;
      rd_a_q <= rd_a_d;
      wr_a_q <= wr_a_d;
      q_q <= q_d;
      q_oe_q <= q_oe_d;
      wr_ready_q <= fifo_in_ready;
    end
  end

  assign q_o = q_q;
  assign q_oe_o = q_oe_q;
  assign wr_ready_o = wr_ready_q;

  assign push = rise & wr_hit;
  assign push_data = {wr_addr, byte_lane_write_select_n_i, d_i};

  // write beats queue here; the array write port takes one beat per cycle
  // even while a read word launches, so streaming never drops a beat
  qsps_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) qsps_fifo_i (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data),
    .out_valid_o(dr_valid),
    .out_ready_i(1'b1),
    .out_data_o(dr_data)
  );

  always_comb begin
    dr_fire = dr_valid;
    dr_addr = dr_data[FW-1 -: ADDR_W];
    dr_sel_n = dr_data[DATA_W +: LANE_N];
    dr_word = dr_data[DATA_W-1:0];
    dr_old = mem_q[dr_addr];
    for (int l = 0; l < LANE_N; l++) begin
      dr_merged[l*LANE_W +: LANE_W] = dr_sel_n[l] ?
        dr_old[l*LANE_W +: LANE_W] : dr_word[l*LANE_W +: LANE_W];
    end
  end

  // array write port
  always_ff @(posedge clk_sys_i) begin
    if (dr_fire) begin
      mem_q[dr_addr] <= dr_merged;
    end
  end

  // helper values for the checks below
  logic [DATA_W-1:0] rd_next_word;
  assign rd_next_word = mem_q[rd_a_q[RD_FIRST+1] + ADDR_W'(1)];

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  reset_quiet_a: assert property (
    @(posedge clk_sys_i) disable iff (1'b0)
    !rst_n_i |=> !q_oe_o && rd_v_q == '0 && wr_v_q == '0)
    else $error("outputs driven after reset");
  rd_launch_a: assert property (rise && rd_v_q[5] |=> q_oe_o)
    else $error("first read word not launched");
  rd_burst_a: assert property (
    rise && rd_v_q[6] |=> q_o == $past(rd_next_word))
    else $error("second burst word from wrong address");
  rd_repeat_a: assert property (k_rise_i && rd_prev_q |=> !rd_v_q[1])
    else $error("back-to-back read accepted");
  wr_repeat_a: assert property (k_rise_i && wr_prev_q |=> !wr_v_q[1])
    else $error("back-to-back write accepted");
  wr_beat_a: assert property (rise && wr_v_q[WR_FIRST] |-> push)
    else $error("write beat not captured");
  nop_idle_a: assert property (
    rise && rd_v_q == '0 && wr_v_q == '0 |=> !q_oe_o ##0 !push)
    else $error("activity without a request");
  clk_hold_a: assert property (
    !rise |=> $stable(q_o) && $stable(q_oe_o) && $stable(rd_v_q))
    else $error("state moved without a rise");
  lane_keep_a: assert property (dr_fire && dr_sel_n[0] |=>
    mem_q[$past(dr_addr)][LANE_W-1:0] == $past(dr_old[LANE_W-1:0]))
    else $error("masked lane altered");

  read_burst_c: cover property (rise && rd_v_q[RD_LAST]);
  write_burst_c: cover property (rise && wr_v_q[WR_LAST]);
  repeat_req_c: cover property (k_rise_i && rd_prev_q && !read_port_select_n_i);
  drain_read_c: cover property (rise && rd_hit && dr_fire);
endmodule : qsps_sequencer

//--- include/qsps_pkg.sv
// shared constants for the burst-of-four sram port sequencer
package qsps_pkg;
  // word and byte-lane layout
  localparam int unsigned DATA_W = 18;
  localparam int unsigned LANE_W = 9;
  localparam int unsigned LANE_N = 2;
  // documented address width (4M words)
  localparam int unsigned ADDR_W_DEF = 22;
  // words per burst
  localparam int unsigned BURST_N = 4;
  // clock-rise pipeline length, counted in true and complement rises
  localparam int unsigned PIPE_N = 8;
  // rise numbers after the request rise at which read words leave
  localparam int unsigned RD_FIRST = 5;
  localparam int unsigned RD_LAST = 8;
  // rise numbers after the request rise at which write words arrive
  localparam int unsigned WR_FIRST = 2;
  localparam int unsigned WR_LAST = 5;
  // depth of the write-beat buffer
  localparam int unsigned FIFO_DEPTH_DEF = 8;
  // reset values
  localparam logic [DATA_W-1:0] Q_RESET = 18'h00000;
endpackage : qsps_pkg

//--- rtl/qsps_fifo.sv
// small synchronous fifo with valid and ready on both sides
module qsps_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);

  // refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("qsps_fifo: DEPTH must be a power of two of at least 2");
  end
  if (WIDTH < 1) begin : g_width_chk
    $error("qsps_fifo: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [PW:0] count_q, count_d;
  logic push, pop;

  // honest full and empty straight from the occupancy count
  assign in_ready_o = (count_q != (PW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // next pointer and count values
  always_comb begin
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // pointer and count registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end
endmodule : qsps_fifo

//--- testbench/qsps_ctrl.sv
// controller model: rise pulses, selects, address and write beats
module qsps_ctrl (
  input wire logic clk_sys_i,
  output logic k_rise_o,
  output logic kn_rise_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [5:0] addr_o,
  output logic [17:0] d_o,
  output logic [1:0] lane_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] cmd_q[$];
  logic [19:0] wq[$];
  int unsigned exp_t[$];
  logic [17:0] exp_w[$];
  int unsigned due_q[$];
  logic [5:0] dad_q[$];
  logic [17:0] ref_mem[64];
  bit run;
  bit ph;
  int unsigned cyc;
  int unsigned rn;
  // one step per system clock, rises only while running
  always @(posedge clk_sys_i) begin
    logic [8:0] c;
    logic [5:0] a, x;
    logic [17:0] dd;
    logic [1:0] s;
    logic r_n, w_n, kr, knr;
    cyc++;
    {r_n, w_n, a, s} = 10'($urandom);
    dd = ~d_o;
    kr = 1'b0;
    knr = 1'b0;
    if (!run) begin
      foreach (exp_t[i]) if (exp_t[i] > cyc) exp_t[i]++;
    end else begin
      ph = !ph;
      rn++;
      kr = ph;
      knr = !ph;
      if (ph) begin
        c = cmd_q.size() ? cmd_q.pop_front() : 9'h0C0;
        {r_n, w_n, a} = c[7:0];
        for (int i = 0; i < 4; i++) begin
          if (c[8] && !r_n) begin
            exp_t.push_back(cyc + 6 + i);
            exp_w.push_back(ref_mem[6'(a + i)]);
          end
          if (c[8] && !w_n) begin
            due_q.push_back(rn + 2 + i);
            dad_q.push_back(6'(a + i));
          end
        end
      end
      if (due_q.size() && due_q[0] == rn) begin
        void'(due_q.pop_front());
        x = dad_q.pop_front();
        {s, dd} = wq.pop_front();
        if (!s[0]) ref_mem[x][8:0] = dd[8:0];
        if (!s[1]) ref_mem[x][17:9] = dd[17:9];
      end
    end
    k_rise_o <= kr;
    kn_rise_o <= knr;
    rd_n_o <= r_n;
    wr_n_o <= w_n;
    addr_o <= a;
    d_o <= dd;
    lane_n_o <= s;
  end
endmodule : qsps_ctrl

//--- testbench/quad_rate_sram_port_sequencer_bench.sv
// self-checking bench for the burst-of-four sram port sequencer
module quad_rate_sram_port_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import qsps_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic k_rise, kn_rise, rd_n, wr_n, q_oe, wr_ready;
  logic [5:0] addr;
  logic [DATA_W-1:0] d, q;
  logic [LANE_N-1:0] lane_n;
  logic rise_q = 1'b0;
  logic full_seen = 1'b0;
  int n_errors = 0;
  int checked = 0;
  // 250 MHz system clock
  always #2 clk_sys_i = ~clk_sys_i;
  qsps_sequencer #(.ADDR_W(6), .FIFO_DEPTH(8)) qsps_sequencer_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .k_rise_i(k_rise),
    .kn_rise_i(kn_rise), .read_port_select_n_i(rd_n),
    .write_port_select_n_i(wr_n), .addr_i(addr), .d_i(d),
    .byte_lane_write_select_n_i(lane_n), .q_o(q), .q_oe_o(q_oe),
    .wr_ready_o(wr_ready));
  qsps_ctrl qsps_ctrl_i (
    .clk_sys_i(clk_sys_i), .k_rise_o(k_rise), .kn_rise_o(kn_rise),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .d_o(d),
    .lane_n_o(lane_n));
  // compare and count
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // queue one command, its write beats and an optional idle k
  task automatic cmd(bit dat, bit r_n, bit w_n, int a, logic [7:0] sel,
                     bit gap);
    qsps_ctrl_i.cmd_q.push_back({dat, r_n, w_n, 6'(a)});
    for (int i = 0; i < 4; i++) begin
      if (dat && !w_n)
        qsps_ctrl_i.wq.push_back({sel[2*i+:2], 18'($urandom)});
    end
    if (gap) qsps_ctrl_i.cmd_q.push_back(9'h0C0);
  endtask : cmd
  // wait for commands and words to finish, then let the buffer drain
  task automatic settle(string nm);
    int n = 0;
    while ((qsps_ctrl_i.cmd_q.size() || qsps_ctrl_i.exp_w.size())
           && n < 3000) begin
      @(posedge clk_sys_i);
      n++;
    end
    repeat (24) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    $display("test %s done", nm);
  endtask : settle
  task automatic wrap_up;
    chk("words left", qsps_ctrl_i.exp_w.size(), 0);
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  // rise marker one cycle late, buffer refusal seen
  always @(posedge clk_sys_i) begin
    rise_q <= k_rise | kn_rise;
    if (wr_ready === 1'b0) full_seen <= 1'b1;
  end
  // each launched word against the oldest note
  always @(negedge clk_sys_i) begin
    if (rise_q && q_oe === 1'b1) begin
      if (qsps_ctrl_i.exp_w.size() == 0) begin
        chk("stray q_oe", 1, 0);
      end else begin
        chk("q", q, qsps_ctrl_i.exp_w.pop_front());
        chk("time", qsps_ctrl_i.cyc, qsps_ctrl_i.exp_t.pop_front());
      end
    end
  end
  // watchdog: the tests need under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    wrap_up();
  end
  // test sequence
  initial begin
    void'($urandom(32'hB7BEC367));
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    qsps_ctrl_i.run <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("q_oe", q_oe, 0);
    chk("wr_ready", wr_ready, 1);
    $display("test reset done");
    for (int b = 0; b < 16; b++) cmd(1, 1, 0, b * 4, 8'h00, 1);
    settle("fill");
    for (int b = 0; b < 16; b++) cmd(1, 0, 1, b * 4, 8'h00, 1);
    settle("read");
    cmd(1, 1, 0, 62, 8'hE4, 1);
    settle("lane write");
    cmd(1, 0, 1, 62, 8'h00, 1);
    settle("lane read");
    cmd(1, 1, 0, 8, 8'h00, 0);
    cmd(0, 1, 0, 16, 8'h00, 1);
    settle("double write");
    cmd(1, 0, 1, 8, 8'h00, 0);
    cmd(0, 0, 1, 16, 8'h00, 1);
    cmd(1, 0, 1, 16, 8'h00, 1);
    settle("double read");
    cmd(1, 0, 1, 20, 8'h00, 1);
    repeat (8) @(posedge clk_sys_i);
    qsps_ctrl_i.run <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    qsps_ctrl_i.run <= 1'b1;
    settle("stop");
    full_seen = 1'b0;
    for (int i = 0; i < 8; i++) begin
      cmd(1, 0, 1, i * 4, 8'h00, 0);
      cmd(1, 1, 0, 32 + i * 4, 8'h00, 0);
    end
    settle("stream");
    chk("full seen", full_seen, 0);
    chk("drained", wr_ready, 1);
    for (int i = 0; i < 8; i++) cmd(1, 0, 1, 32 + i * 4, 8'h00, 1);
    settle("stream read");
    wrap_up();
  end
endmodule : quad_rate_sram_port_sequencer_bench
